// ---- sadi_consts.vh ----
// Address map, target codes and interrupt line numbers for the system decoder
`ifndef SADI_CONSTS_VH
`define SADI_CONSTS_VH

// Target codes returned by the address decode function
`define SADI_TGT_NONE 4'h0
`define SADI_TGT_FLASH 4'h1
`define SADI_TGT_SRAM 4'h2
`define SADI_TGT_EXP0 4'h3
`define SADI_TGT_EXP1 4'h4
`define SADI_TGT_APB 4'h5
`define SADI_TGT_GPIO 4'h6
`define SADI_TGT_SYSCTL 4'h7
`define SADI_TGT_BOARD 4'h8

// External memory windows reached through expansion port one
`define SADI_EXT_NONE 2'h0
`define SADI_EXT_SSRAM1 2'h1
`define SADI_EXT_SSRAM23 2'h2
`define SADI_EXT_PSRAM 2'h3

// Region bounds
`define SADI_FLASH_END 32'h0003ffff
`define SADI_SSRAM1_BASE 32'h00400000
`define SADI_SSRAM1_END 32'h007fffff
`define SADI_CODE_END 32'h1fffffff
`define SADI_SRAM_BASE 32'h20000000
`define SADI_SRAM_END 32'h2001ffff
`define SADI_SSRAM23_BASE 32'h20400000
`define SADI_SSRAM23_END 32'h207fffff
`define SADI_PSRAM_BASE 32'h21000000
`define SADI_PSRAM_END 32'h21ffffff
`define SADI_SRAM_ALIAS_BASE 32'h22000000
`define SADI_SRAM_ALIAS_END 32'h23ffffff
`define SADI_RAM_END 32'h3fffffff
`define SADI_APB_BASE 32'h40000000
`define SADI_APB_END 32'h4000ffff
`define SADI_GPIO_BASE 32'h40010000
`define SADI_GPIO_END 32'h40013fff
`define SADI_SYSCTL_BASE 32'h4001f000
`define SADI_SYSCTL_END 32'h4001ffff
`define SADI_BOARD_BASE 32'h40020000
`define SADI_BOARD_END 32'h4002ffff
`define SADI_PER_ALIAS_BASE 32'h42000000
`define SADI_PER_ALIAS_END 32'h43ffffff
`define SADI_PER_BASE 32'h40000000
`define SADI_PER_EXP_BASE 32'h41140000
`define SADI_PER_EXP_END 32'h5fffffff
`define SADI_XRAM_BASE 32'h60000000
`define SADI_DEV_EXP0_BASE 32'ha0000000
`define SADI_DEV_EXP0_END 32'ha000ffff
`define SADI_DEV_END 32'hdfffffff

// Field positions
`define SADI_SRAM_BANK_HI 16
`define SADI_SRAM_BANK_LO 15
`define SADI_SLOT_HI 15
`define SADI_SLOT_LO 12
`define SADI_GPIO_HI 13
`define SADI_GPIO_LO 12
`define SADI_ALIAS_WORD_HI 24
`define SADI_ALIAS_WORD_LO 7
`define SADI_ALIAS_BIT_HI 6
`define SADI_ALIAS_BIT_LO 2
`define SADI_HSIZE_WORD 3'h2

// Processor interrupt line numbers
`define SADI_IRQ_UART0 0
`define SADI_IRQ_UART1 2
`define SADI_IRQ_RTC 5
`define SADI_IRQ_GPIO0_ALL 6
`define SADI_IRQ_GPIO1_ALL 7
`define SADI_IRQ_TIMER0 8
`define SADI_IRQ_TIMER1 9
`define SADI_IRQ_DUALTIMER 10
`define SADI_IRQ_UART_OVF 12
`define SADI_IRQ_TOUCH 15
`define SADI_IRQ_GPIO0_PIN 16
`define SADI_IRQ_GPIO2_ALL 42
`define SADI_IRQ_GPIO3_ALL 43
`define SADI_IRQ_RNG 44
`define SADI_IRQ_SHIELD_UART 45
`define SADI_IRQ_ETH 47
`define SADI_IRQ_I2S 48
`define SADI_IRQ_SPI 49
`define SADI_IRQ_GPIO4_ALL 54
`define SADI_IRQ_GPIO5_ALL 55
`define SADI_IRQ_UART4 56

`endif

// ---- sadi_irq_map.v ----
// Fixed routing of peripheral interrupts onto processor interrupt lines
`timescale 1ns/100ps
`default_nettype none
`include "sadi_consts.vh"

module sadi_irq_map #(
  parameter IRQ_NUM = 64
) (
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  input wire wdog_irq,
  input wire uart0_irq,
  input wire uart1_irq,
  input wire uart4_irq,
  input wire [4:0] uart_ovf_irq,
  input wire rtc_irq,
  input wire [5:0] gpio_all_irq,
  input wire [15:0] gpio0_pin_irq,
  input wire timer0_irq,
  input wire timer1_irq,
  input wire dualtimer_irq,
  input wire touch_irq,
  input wire rng_irq,
  input wire [1:0] shield_uart_irq,
  input wire eth_irq,
  input wire i2s_irq,
  input wire [4:0] spi_irq,
  output reg nmi_q,
  output reg [IRQ_NUM-1:0] processor_irq_lines_q
);

  reg [IRQ_NUM-1:0] irq_d;

  ////////////////////////////////////////////////////////////////
  always @* begin
    irq_d = {IRQ_NUM{1'b0}};
    irq_d[`SADI_IRQ_UART0] = uart0_irq;
    irq_d[`SADI_IRQ_UART1] = uart1_irq;
    irq_d[`SADI_IRQ_RTC] = rtc_irq;
    irq_d[`SADI_IRQ_GPIO0_ALL] = gpio_all_irq[0];
    irq_d[`SADI_IRQ_GPIO1_ALL] = gpio_all_irq[1];
    irq_d[`SADI_IRQ_TIMER0] = timer0_irq;
    irq_d[`SADI_IRQ_TIMER1] = timer1_irq;
    irq_d[`SADI_IRQ_DUALTIMER] = dualtimer_irq;
    irq_d[`SADI_IRQ_UART_OVF] = |uart_ovf_irq;
    irq_d[`SADI_IRQ_TOUCH] = touch_irq;
    irq_d[`SADI_IRQ_GPIO0_PIN +: 16] = gpio0_pin_irq;
    irq_d[`SADI_IRQ_GPIO2_ALL] = gpio_all_irq[2];
    irq_d[`SADI_IRQ_GPIO3_ALL] = gpio_all_irq[3];
    irq_d[`SADI_IRQ_RNG] = rng_irq;
    irq_d[`SADI_IRQ_SHIELD_UART +: 2] = shield_uart_irq;
    irq_d[`SADI_IRQ_ETH] = eth_irq;
    irq_d[`SADI_IRQ_I2S] = i2s_irq;
    irq_d[`SADI_IRQ_SPI +: 5] = spi_irq;
    irq_d[`SADI_IRQ_GPIO4_ALL] = gpio_all_irq[4];
    irq_d[`SADI_IRQ_GPIO5_ALL] = gpio_all_irq[5];
    irq_d[`SADI_IRQ_UART4] = uart4_irq;
  end

  // One flop stage keeps the core's inputs glitch free after the OR
  always @(posedge core_clk) begin
    if (srst) begin
      processor_irq_lines_q <= {IRQ_NUM{1'b0}};
      nmi_q <= 1'b0;
    end else if (clk_en) begin
      processor_irq_lines_q <= irq_d;
      nmi_q <= wdog_irq;
    end
  end

endmodule // sadi_irq_map
`default_nettype wire

// ---- sadi_system_decode.v ----
// System address decoder with bit-band alias translation and interrupt routing
//
// Contract
// - Alias word maps to one base bit
// - Alias uses data bit zero only
// - Base regions accept normal sized accesses
// - Flash low 256KB, other code to port one
// - Four 32KB SRAM banks in order
// - SSRAM1 window goes via port one
// - SSRAM2/3 window goes via port one
// - PSRAM window goes via port one
// - 4KB APB slots numbered from zero
// - Random source at APB slot fifteen
// - Four GPIO blocks in 4KB slots
// - System controller slot at 0x4001F000
// - Unclaimed upper peripheral space to port one
// - Both external RAM regions to port one
// - Device 64KB to port zero, rest one
// - Serial port 0 to line 0
// - Serial port 1 to line 2
// - All overflows ORed onto line 12
// - GPIO0 pins to lines 16..31
// - Random source interrupt to line 44
// - Shield serial 45/46, Ethernet 47
// - SPI controllers to lines 49..53
`timescale 1ns/100ps
`default_nettype none
`include "sadi_consts.vh"

module sadi_system_decode #(
  parameter IRQ_NUM = 64
) (
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] tgt_rdata,
  input wire tgt_ready,
  input wire wdog_irq,
  input wire uart0_irq,
  input wire uart1_irq,
  input wire uart4_irq,
  input wire [4:0] uart_ovf_irq,
  input wire rtc_irq,
  input wire [5:0] gpio_all_irq,
  input wire [15:0] gpio0_pin_irq,
  input wire timer0_irq,
  input wire timer1_irq,
  input wire dualtimer_irq,
  input wire touch_irq,
  input wire rng_irq,
  input wire [1:0] shield_uart_irq,
  input wire eth_irq,
  input wire i2s_irq,
  input wire [4:0] spi_irq,
  output reg code_flash_target_port_q,
  output reg [3:0] sram_bank_target_port_q,
  output reg expansion_port_zero_q,
  output reg expansion_port_one_q,
  output reg [15:0] apb_slot_sel_q,
  output reg [3:0] gpio_sel_q,
  output reg system_controller_slot_q,
  output reg [15:0] board_slot_sel_q,
  output reg [1:0] ext_region_q,
  output reg decode_err_q,
  output reg [31:0] tgt_addr_q,
  output reg tgt_write_q,
  output reg [2:0] tgt_size_q,
  output reg bitband_q,
  output reg [4:0] bit_idx_q,
  output reg [31:0] tgt_wdata_q,
  output reg [31:0] tgt_wmask_q,
  output reg [31:0] hrdata_q,
  output reg rdata_valid_q,
  output wire nmi_q,
  output wire [IRQ_NUM-1:0] processor_irq_lines_q
);

  ////////////////////////////////////////////////////////////////
  // Address decode shared by direct and alias-translated accesses

  function in_range;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function [3:0] decode_tgt;
    input [31:0] a;
    begin
      if (in_range(a, 32'h00000000, `SADI_FLASH_END)) begin
        decode_tgt = `SADI_TGT_FLASH;
      end else if (in_range(a, 32'h00000000, `SADI_CODE_END)) begin
        decode_tgt = `SADI_TGT_EXP1;
      end else if (in_range(a, `SADI_SRAM_BASE, `SADI_SRAM_END)) begin
        decode_tgt = `SADI_TGT_SRAM;
      end else if (in_range(a, `SADI_SRAM_ALIAS_BASE, `SADI_SRAM_ALIAS_END)) begin
        decode_tgt = `SADI_TGT_NONE;
      end else if (in_range(a, `SADI_SRAM_BASE, `SADI_RAM_END)) begin
        decode_tgt = `SADI_TGT_EXP1;
      end else if (in_range(a, `SADI_APB_BASE, `SADI_APB_END)) begin
        decode_tgt = `SADI_TGT_APB;
      end else if (in_range(a, `SADI_GPIO_BASE, `SADI_GPIO_END)) begin
        decode_tgt = `SADI_TGT_GPIO;
      end else if (in_range(a, `SADI_SYSCTL_BASE, `SADI_SYSCTL_END)) begin
        decode_tgt = `SADI_TGT_SYSCTL;
      end else if (in_range(a, `SADI_BOARD_BASE, `SADI_BOARD_END)) begin
        decode_tgt = `SADI_TGT_BOARD;
      end else if (in_range(a, `SADI_PER_ALIAS_BASE, `SADI_PER_ALIAS_END)) begin
        decode_tgt = `SADI_TGT_NONE;
      end else if (in_range(a, `SADI_PER_EXP_BASE, `SADI_PER_EXP_END)) begin
        decode_tgt = `SADI_TGT_EXP1;
      end else if (in_range(a, `SADI_DEV_EXP0_BASE, `SADI_DEV_EXP0_END)) begin
        decode_tgt = `SADI_TGT_EXP0;
      end else if (in_range(a, `SADI_XRAM_BASE, `SADI_DEV_END)) begin
        decode_tgt = `SADI_TGT_EXP1;
      end else begin
        decode_tgt = `SADI_TGT_NONE;
      end
    end
  endfunction

  // Word address of the base word holding the aliased bit
  function [31:0] alias_word;
    input [31:0] base;
    input [31:0] a;
    begin
      alias_word = base + {12'h000, a[`SADI_ALIAS_WORD_HI:`SADI_ALIAS_WORD_LO], 2'b00};
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Address phase: translation and decode, all combinational

  wire addr_phase = htrans[1] & hready;
  wire sram_alias = in_range(haddr, `SADI_SRAM_ALIAS_BASE, `SADI_SRAM_ALIAS_END);
  wire per_alias = in_range(haddr, `SADI_PER_ALIAS_BASE, `SADI_PER_ALIAS_END);
  wire alias_hit = sram_alias | per_alias;
  wire [31:0] eff_addr = sram_alias ? alias_word(`SADI_SRAM_BASE, haddr) :
                         per_alias ? alias_word(`SADI_PER_BASE, haddr) : haddr;
  wire [3:0] tgt = decode_tgt(eff_addr);

  reg flash_d;
  reg [3:0] sram_d;
  reg exp0_d;
  reg exp1_d;
  reg [15:0] apb_d;
  reg [3:0] gpio_d;
  reg sysctl_d;
  reg [15:0] board_d;
  reg [1:0] ext_d;
  reg err_d;

  always @* begin
    flash_d = 1'b0;
    sram_d = 4'h0;
    exp0_d = 1'b0;
    exp1_d = 1'b0;
    apb_d = 16'h0000;
    gpio_d = 4'h0;
    sysctl_d = 1'b0;
    board_d = 16'h0000;
    ext_d = `SADI_EXT_NONE;
    err_d = 1'b0;
    case (tgt)
      `SADI_TGT_FLASH: flash_d = 1'b1;
      `SADI_TGT_SRAM: sram_d[eff_addr[`SADI_SRAM_BANK_HI:`SADI_SRAM_BANK_LO]] = 1'b1;
      `SADI_TGT_EXP0: exp0_d = 1'b1;
      `SADI_TGT_EXP1: exp1_d = 1'b1;
      `SADI_TGT_APB: apb_d[eff_addr[`SADI_SLOT_HI:`SADI_SLOT_LO]] = 1'b1;
      `SADI_TGT_GPIO: gpio_d[eff_addr[`SADI_GPIO_HI:`SADI_GPIO_LO]] = 1'b1;
      `SADI_TGT_SYSCTL: sysctl_d = 1'b1;
      `SADI_TGT_BOARD: board_d[eff_addr[`SADI_SLOT_HI:`SADI_SLOT_LO]] = 1'b1;
      default: err_d = 1'b1;
    endcase
    // Which memory sits behind port one, for its own chip selects
    if (in_range(eff_addr, `SADI_SSRAM1_BASE, `SADI_SSRAM1_END)) begin
      ext_d = `SADI_EXT_SSRAM1;
    end else if (in_range(eff_addr, `SADI_SSRAM23_BASE, `SADI_SSRAM23_END)) begin
      ext_d = `SADI_EXT_SSRAM23;
    end else if (in_range(eff_addr, `SADI_PSRAM_BASE, `SADI_PSRAM_END)) begin
      ext_d = `SADI_EXT_PSRAM;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Data phase: selects held until the next ready cycle, then reloaded or cleared

  always @(posedge core_clk) begin
    if (srst) begin
      code_flash_target_port_q <= 1'b0;
      sram_bank_target_port_q <= 4'h0;
      expansion_port_zero_q <= 1'b0;
      expansion_port_one_q <= 1'b0;
      apb_slot_sel_q <= 16'h0000;
      gpio_sel_q <= 4'h0;
      system_controller_slot_q <= 1'b0;
      board_slot_sel_q <= 16'h0000;
      ext_region_q <= `SADI_EXT_NONE;
      decode_err_q <= 1'b0;
      tgt_addr_q <= 32'h00000000;
      tgt_write_q <= 1'b0;
      tgt_size_q <= 3'h0;
      bitband_q <= 1'b0;
      bit_idx_q <= 5'h00;
    end else if (clk_en && hready) begin
      // Idle or busy transfers clear every select; a stalled bus holds them
      code_flash_target_port_q <= addr_phase & flash_d;
      sram_bank_target_port_q <= addr_phase ? sram_d : 4'h0;
      expansion_port_zero_q <= addr_phase & exp0_d;
      expansion_port_one_q <= addr_phase & exp1_d;
      apb_slot_sel_q <= addr_phase ? apb_d : 16'h0000;
      gpio_sel_q <= addr_phase ? gpio_d : 4'h0;
      system_controller_slot_q <= addr_phase & sysctl_d;
      board_slot_sel_q <= addr_phase ? board_d : 16'h0000;
      ext_region_q <= addr_phase ? ext_d : `SADI_EXT_NONE;
      decode_err_q <= addr_phase & err_d;
      tgt_addr_q <= eff_addr;
      tgt_write_q <= addr_phase & hwrite;
      // Alias accesses become word accesses; base accesses keep their size
      tgt_size_q <= alias_hit ? `SADI_HSIZE_WORD : hsize;
      bitband_q <= addr_phase & alias_hit;
      bit_idx_q <= haddr[`SADI_ALIAS_BIT_HI:`SADI_ALIAS_BIT_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Write and read data. Alias writes present the single bit as a lane mask,
  // so the target performs the bit update; no read-modify-write is done here.

  always @(posedge core_clk) begin
    if (srst) begin
      tgt_wdata_q <= 32'h00000000;
      tgt_wmask_q <= 32'h00000000;
      hrdata_q <= 32'h00000000;
      rdata_valid_q <= 1'b0;
    end else if (clk_en) begin
      if (bitband_q) begin
        tgt_wdata_q <= {32{hwdata[0]}};
        tgt_wmask_q <= 32'h00000001 << bit_idx_q;
      end else begin
        tgt_wdata_q <= hwdata;
        tgt_wmask_q <= 32'hffffffff;
      end
      rdata_valid_q <= tgt_ready & ~tgt_write_q & ~decode_err_q;
      if (tgt_ready) begin
        hrdata_q <= bitband_q ? {31'h00000000, tgt_rdata[bit_idx_q]} : tgt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  sadi_irq_map #(
    .IRQ_NUM(IRQ_NUM)
  ) u_irq_map (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .wdog_irq(wdog_irq),
    .uart0_irq(uart0_irq),
    .uart1_irq(uart1_irq),
    .uart4_irq(uart4_irq),
    .uart_ovf_irq(uart_ovf_irq),
    .rtc_irq(rtc_irq),
    .gpio_all_irq(gpio_all_irq),
    .gpio0_pin_irq(gpio0_pin_irq),
    .timer0_irq(timer0_irq),
    .timer1_irq(timer1_irq),
    .dualtimer_irq(dualtimer_irq),
    .touch_irq(touch_irq),
    .rng_irq(rng_irq),
    .shield_uart_irq(shield_uart_irq),
    .eth_irq(eth_irq),
    .i2s_irq(i2s_irq),
    .spi_irq(spi_irq),
    .nmi_q(nmi_q),
    .processor_irq_lines_q(processor_irq_lines_q)
  );

endmodule // sadi_system_decode
`default_nettype wire

// ---- sadi_chk.sv ----
// Checker of decode timing, alias translation and interrupt routing
`timescale 1ns/100ps
`default_nettype none
module sadi_chk #(
  parameter IRQ_NUM = 64
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] tgt_rdata,
  input wire logic tgt_ready,
  input wire logic uart0_irq,
  input wire logic uart1_irq,
  input wire logic [4:0] uart_ovf_irq,
  input wire logic [15:0] gpio0_pin_irq,
  input wire logic rng_irq,
  input wire logic [1:0] shield_uart_irq,
  input wire logic eth_irq,
  input wire logic i2s_irq,
  input wire logic wdog_irq,
  input wire logic [4:0] spi_irq,
  input wire logic code_flash_target_port_q,
  input wire logic [3:0] sram_bank_target_port_q,
  input wire logic expansion_port_zero_q,
  input wire logic [15:0] board_slot_sel_q,
  input wire logic decode_err_q,
  input wire logic tgt_write_q,
  input wire logic [2:0] tgt_size_q,
  input wire logic rdata_valid_q,
  input wire logic nmi_q,
  input wire logic [31:0] tgt_addr_q,
  input wire logic bitband_q,
  input wire logic [4:0] bit_idx_q,
  input wire logic [31:0] tgt_wdata_q,
  input wire logic [31:0] tgt_wmask_q,
  input wire logic [31:0] hrdata_q,
  input wire logic [IRQ_NUM-1:0] processor_irq_lines_q
);
  // Lines with no source: 1,3,4,11,13,14,32..41,57..63
  localparam logic [63:0] RSV = 64'hfe0003ff0000681a;
  wire tk;
  wire rbit;
  wire ab;
  assign tk = clk_en & hready & htrans[1];
  // Either alias window, the only accesses whose size is forced to a word
  assign ab = haddr[31:25] == 7'h11 || haddr[31:25] == 7'h21;
  assign rbit = tgt_rdata[bit_idx_q];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  //////////////////////////////////////////////
  AST_FLASH: assert property (tk && haddr[31:18] == 14'h0 |=> code_flash_target_port_q)
    else $error("flash select missing");
  AST_SRAM: assert property (tk && haddr[31:17] == 15'h1000 |=>
    sram_bank_target_port_q == 4'h1 << $past(haddr[16:15])) else $error("wrong sram bank");
  AST_DEV0: assert property (tk && haddr[31:16] == 16'ha000 |=> expansion_port_zero_q)
    else $error("device window not on port zero");
  AST_ALIAS: assert property (tk && haddr[31:25] == 7'h11 |=> bitband_q &&
    tgt_addr_q == {12'h200, $past(haddr[24:7]), 2'b00} && bit_idx_q == $past(haddr[6:2]))
    else $error("alias translation wrong");
  AST_WDATA: assert property (clk_en |=> tgt_wdata_q ==
    ($past(bitband_q) ? {32{$past(hwdata[0])}} : $past(hwdata))) else $error("write data wrong");
  AST_WMASK: assert property (clk_en |=> tgt_wmask_q ==
    ($past(bitband_q) ? 32'h1 << $past(bit_idx_q) : 32'hffffffff)) else $error("write mask wrong");
  AST_RDATA: assert property (clk_en && tgt_ready |=> hrdata_q ==
    ($past(bitband_q) ? {31'h0, $past(rbit)} : $past(tgt_rdata))) else $error("read data wrong");
  AST_IRQ_LO: assert property (clk_en |=> processor_irq_lines_q[0] == $past(uart0_irq) &&
    processor_irq_lines_q[2] == $past(uart1_irq) && processor_irq_lines_q[12] == |$past(uart_ovf_irq))
    else $error("serial interrupt lines wrong");
  AST_IRQ_GPIO: assert property (clk_en |=> processor_irq_lines_q[31:16] == $past(gpio0_pin_irq))
    else $error("pin interrupt lines wrong");
  AST_IRQ_HI: assert property (clk_en |=> processor_irq_lines_q[53:44] ==
    {$past(spi_irq), $past(i2s_irq), $past(eth_irq), $past(shield_uart_irq), $past(rng_irq)})
    else $error("upper interrupt lines wrong");
  AST_IRQ_RSV: assert property ((processor_irq_lines_q & RSV[IRQ_NUM-1:0]) == '0)
    else $error("reserved interrupt line active");
  AST_STALL: assert property (!hready |=> $stable(tgt_addr_q) && $stable(bitband_q))
    else $error("select changed during wait");
  cover property (tk && haddr[31:25] == 7'h11);
  cover property (!hready ##1 tk);
  AST_SIZE: assert property (tk |=> tgt_write_q == $past(hwrite) &&
    tgt_size_q == ($past(ab) ? 3'h2 : $past(hsize))) else $error("size or direction wrong");
  AST_BOARD: assert property (tk && haddr[31:16] == 16'h4002 |=>
    board_slot_sel_q == 16'h1 << $past(haddr[15:12])) else $error("board slot select wrong");
  AST_RVALID: assert property (clk_en |=> rdata_valid_q ==
    ($past(tgt_ready) && !$past(tgt_write_q) && !$past(decode_err_q))) else $error("read valid wrong");
  AST_NMI: assert property (clk_en |=> nmi_q == $past(wdog_irq))
    else $error("watchdog line wrong");
  cover property (tk && haddr[31:16] == 16'ha000);
  cover property (tk && haddr[31:16] == 16'h4002);
endmodule // sadi_chk
bind sadi_system_decode sadi_chk #(.IRQ_NUM(IRQ_NUM)) chk_u (.core_clk, .srst, .clk_en, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .tgt_rdata, .tgt_ready, .uart0_irq, .uart1_irq, .uart_ovf_irq,
  .gpio0_pin_irq, .rng_irq, .shield_uart_irq, .eth_irq, .i2s_irq, .wdog_irq, .spi_irq,
  .code_flash_target_port_q, .sram_bank_target_port_q, .expansion_port_zero_q, .board_slot_sel_q,
  .decode_err_q, .tgt_write_q, .tgt_size_q, .rdata_valid_q, .nmi_q, .tgt_addr_q, .bitband_q, .bit_idx_q,
  .tgt_wdata_q, .tgt_wmask_q, .hrdata_q, .processor_irq_lines_q);
`default_nettype wire

// ---- sadi_mst_model.sv ----
// Processor-side bus master model issuing pipelined transfers
`timescale 1ns/100ps
`default_nettype none
module sadi_mst_model (
  input wire logic core_clk,
  input wire logic hready,
  output var logic [31:0] haddr,
  output var logic [1:0] htrans,
  output var logic hwrite,
  output var logic [2:0] hsize,
  output var logic [31:0] hwdata
);
  logic [31:0] wd_q;
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wd_q = 32'h0;
  end
  //////////////////////////////////////////////
  // Write data trails its address by one phase, so it rides with the next request
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] d);
    #1;
    haddr = a;
    htrans = 2'h2;
    hwrite = w;
    hsize = s;
    hwdata = wd_q;
    wd_q = d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask
  // An idle phase still carries the pending write data; each later idle flips the lines to their inverse
  task automatic idle();
    #1;
    htrans = 2'h0;
    hwdata = wd_q;
    wd_q = ~wd_q;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask
endmodule // sadi_mst_model
`default_nettype wire

// ---- sadi_tb.sv ----
// Self-checking bench for the system address decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int FL = 28, SR = 24, X0 = 23, X1 = 22, AP = 6, GP = 2, SC = 1, ER = 0;
  logic core_clk = 0, srst = 1, clk_en = 1, hready = 1, tgt_ready = 1, stall = 0, irqph = 0;
  logic [31:0] tgt_rdata = 32'h0, a, b, t;
  logic [45:0] irq_v = 46'h0;
  logic [68:0] obs, e, q[$];
  int fails = 0, n_checks = 0, cyc = 0;
  wire [31:0] haddr, hwdata, ta;
  wire [1:0] htrans, ext;
  wire [2:0] hsize;
  wire [3:0] sr, gp;
  wire [15:0] ap;
  wire [4:0] bi;
  wire hwrite, fl, x0, x1, sc, er, bb;
  sadi_mst_model mst_u (.core_clk, .hready, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  sadi_system_decode dut_u (.core_clk, .srst, .clk_en, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .tgt_rdata, .tgt_ready, .wdog_irq(irq_v[0]), .uart0_irq(irq_v[1]), .uart1_irq(irq_v[2]),
    .uart4_irq(irq_v[3]), .uart_ovf_irq(irq_v[8:4]), .rtc_irq(irq_v[9]), .gpio_all_irq(irq_v[15:10]),
    .gpio0_pin_irq(irq_v[31:16]), .timer0_irq(irq_v[32]), .timer1_irq(irq_v[33]),
    .dualtimer_irq(irq_v[34]), .touch_irq(irq_v[35]), .rng_irq(irq_v[36]), .shield_uart_irq(irq_v[38:37]),
    .eth_irq(irq_v[39]), .i2s_irq(irq_v[40]), .spi_irq(irq_v[45:41]), .code_flash_target_port_q(fl),
    .sram_bank_target_port_q(sr), .expansion_port_zero_q(x0), .expansion_port_one_q(x1),
    .apb_slot_sel_q(ap), .gpio_sel_q(gp), .system_controller_slot_q(sc), .board_slot_sel_q(),
    .ext_region_q(ext), .decode_err_q(er), .tgt_addr_q(ta), .tgt_write_q(), .tgt_size_q(), .bitband_q(bb),
    .bit_idx_q(bi), .tgt_wdata_q(), .tgt_wmask_q(), .hrdata_q(), .rdata_valid_q(), .nmi_q(),
    .processor_irq_lines_q());
  initial forever #5 core_clk = ~core_clk;
  //////////////////////////////////////////////
  always @(posedge core_clk) begin
    #1;
    hready = stall ? 1'($urandom_range(1, 0)) : 1'b1;
    tgt_ready = hready;
    tgt_rdata = $urandom;
    irq_v = {14'($urandom), $urandom};
    if (irqph) clk_en = 1'($urandom_range(1, 0));
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end
  // Outputs are taken mid-cycle, then judged at the edge that ends the data phase
  always @(negedge core_clk) obs = {fl, sr, x0, x1, ap, gp, sc, er, ext, bb, bi, ta};
  always @(posedge core_clk) begin
    if (!srst && hready && clk_en && |obs[68:40]) begin
      e = q.size() ? q.pop_front() : 'x;
      n_checks++;
      if (obs !== e) begin
        fails++;
        $display("MISMATCH decode expected %h got %h", e, obs);
      end
    end
  end
  task automatic go(input logic [31:0] d, input int p, input logic [1:0] x, input logic [31:0] tt,
      input logic bf, input logic [4:0] i);
    q.push_back({29'(1) << p, x, bf, i, tt});
    mst_u.xfer(d, 1'($urandom), bf ? 3'h2 : 3'($urandom_range(2, 0)), $urandom);
  endtask
  task automatic nx(input logic [31:0] d, input int p, input logic [1:0] x);
    go(d, p, x, d, 1'b0, d[6:2]);
  endtask
  task automatic test_done();
    if (q.size() != 0) begin
      fails++;
      $display("MISMATCH pending expected 0 got %0d", q.size());
    end
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h77d8aa67));
    repeat (10) @(posedge core_clk);
    #1 srst = 0;
    @(posedge core_clk);
    nx(32'h0, FL, 2'h0);
    nx(32'h0003fffc, FL, 2'h0);
    nx(32'h00040000, X1, 2'h0);
    nx(32'h00400000, X1, 2'h1);
    nx(32'h007ffffc, X1, 2'h1);
    nx(32'h20007ffc, SR, 2'h0);
    nx(32'h20008000, SR + 1, 2'h0);
    nx(32'h20010000, SR + 2, 2'h0);
    nx(32'h2001fffc, SR + 3, 2'h0);
    nx(32'h20400000, X1, 2'h2);
    nx(32'h21000000, X1, 2'h3);
    nx(32'h21fffffc, X1, 2'h3);
    for (int i = 0; i < 16; i++) nx(32'h40000000 + i * 32'h1000, AP + i, 2'h0);
    for (int i = 0; i < 4; i++) nx(32'h40010000 + i * 32'h1000, GP + i, 2'h0);
    nx(32'h4001f000, SC, 2'h0);
    nx(32'h41140000, X1, 2'h0);
    nx(32'h5ffffffc, X1, 2'h0);
    nx(32'h60000000, X1, 2'h0);
    nx(32'h9ffffffc, X1, 2'h0);
    nx(32'ha0000000, X0, 2'h0);
    nx(32'ha000fffc, X0, 2'h0);
    nx(32'ha0010000, X1, 2'h0);
    nx(32'he0000000, ER, 2'h0);
    go(32'h22000084, SR, 2'h0, 32'h20000004, 1'b1, 5'd1);
    go(32'h220ffffc, SR, 2'h0, 32'h20007ffc, 1'b1, 5'd31);
    go(32'h421e0000, AP + 15, 2'h0, 32'h4000f000, 1'b1, 5'd0);
    stall = 1;
    for (int i = 0; i < 60; i++) begin
      a = 32'h20000000 | ($urandom & 32'h1fffc);
      b = $urandom & 32'h3ffffc;
      t = {12'h200, b[24:7], 2'b00};
      if (i % 2) nx(a, SR + a[16:15], 2'h0);
      else go(32'h22000000 | b, SR + t[16:15], 2'h0, t, 1'b1, b[6:2]);
    end
    stall = 0;
    // Board slots carry no select in the queued view; the checker judges them
    mst_u.xfer(32'h40020000, 1'b0, 3'h2, $urandom);
    mst_u.xfer(32'h4002f000, 1'b1, 3'h2, $urandom);
    mst_u.idle();
    mst_u.idle();
    irqph = 1;
    repeat (200) @(posedge core_clk);
    test_done();
  end
endmodule // tb
`default_nettype wire
